/* File: rtl/ebs_pkg.sv */
// Package: shared types and constants for the external bus cycle sequencer
package ebs_pkg;

   // ----------------------------------------
   // Field widths
   // ----------------------------------------
   localparam int unsigned ADDR_W   = 24;        // Address bus width
   localparam int unsigned DATA_W   = 16;        // Data bus width

   // ----------------------------------------
   // Phase length limits, in system clock periods
   // ----------------------------------------
   localparam logic [1:0] SETUP_BASE_MIN  = 2'h1;  // Address setup normal minimum
   localparam logic [4:0] ACCESS_LEN_MAX  = 5'h1f; // Code 31 means 32 periods
   localparam logic [5:0] ASYNC_MIN_WAIT  = 6'h1;  // Extra wait for async ready

   // ----------------------------------------
   // Timing control record per chip select
   // ----------------------------------------
   typedef struct packed
   {
      logic       addressSetupLen;        // 0: 1 period, 1: 2 periods
      logic [1:0] windowExtraLen;         // Extra periods on window change
      logic [1:0] commandDelayLen;        // 0..3 periods
      logic       writeSetupTristateLen;  // 0..1 period
      logic [4:0] accessLen;              // Code 0..31 gives 1..32 periods
      logic [1:0] holdLen;                // 0..3 periods
      logic       readyEnable;            // Access may be stretched by ready
      logic       readyActiveHigh;        // Polarity of ready input
      logic       readyAsync;             // Ready passes extra sync stage
   } ebs_chip_select_timing_ctrl_s;

   // ----------------------------------------
   // Cycle request
   // ----------------------------------------
   typedef struct packed
   {
      logic              write;           // 1: write cycle, 0: read cycle
      logic [ADDR_W-1:0] addr;            // Target address
      logic [DATA_W-1:0] wdata;           // Write data
      logic [1:0]        chipSel;         // Chip select index
      logic              windowChange;    // Address window differs from last
   } ebs_req_s;

   // ----------------------------------------
   // External bus pins (outputs)
   // ----------------------------------------
   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;            // Address pins
      logic [DATA_W-1:0] dataOut;         // Data output value
      logic              dataOe;          // Data output enable
      logic              readStrobe_n;    // Read strobe, active low
      logic              writeStrobe_n;   // Write strobe, active low
      logic [3:0]        chipSelect_n;    // Chip selects, active low
   } ebs_bus_s;

   // ----------------------------------------
   // Phase states, one-hot
   // ----------------------------------------
   typedef enum logic [5:0]
   {
      PH_IDLE   = 6'h01,
      PH_SETUP  = 6'h02,
      PH_CMD    = 6'h04,
      PH_WSETUP = 6'h08,
      PH_ACCESS = 6'h10,
      PH_HOLD   = 6'h20
   } ebs_phase_e;

endpackage : ebs_pkg

/* File: rtl/ebs_sequencer.sv */
// Module: five-phase external bus cycle sequencer
//
// Contract
// - Cycles run setup, command, wsetup, access, hold
// - Phase lengths per chip select; command 0-3
// - Setup 1-2, plus 0-3 on window change
// - Write setup/tristate phase lasts 0 or 1
// - Access 1-32 periods, ready may extend
// - Hold phase lasts 0 to 3 periods
// - Reference clock out is the system clock
// - Ready polarity selectable; async adds sync stage
// - Ready inactive inserts wait; active ends access
// - Read data captured as strobe rises
`timescale 1ns/1ps
`default_nettype none

module ebs_sequencer
#(
   parameter int unsigned NUM_CS = 4      // Number of chip selects
)
(
   // Clock and reset
   input  wire logic                                   core_clk,
   input  wire logic                                   rst_n,
   // Per chip select timing control
   input  wire ebs_pkg::ebs_chip_select_timing_ctrl_s  chipSelectTimingCtrl [NUM_CS],
   // Cycle request and answer
   input  wire logic                                   reqValid,
   input  wire ebs_pkg::ebs_req_s                      req,
   output var  logic                                   reqReady,
   output var  logic                                   rdataValid,
   output var  logic [ebs_pkg::DATA_W-1:0]             rdata,
   // External bus
   input  wire logic                                   readyIn,
   input  wire logic [ebs_pkg::DATA_W-1:0]             busDataIn,
   output var  ebs_pkg::ebs_bus_s                      bus,
   output var  logic                                   busRefClkOut,
   output var  logic                                   busRefClkHiSpeed
);
   import ebs_pkg::*;

   // ----------------------------------------
   // State record
   // ----------------------------------------
   typedef struct packed
   {
      ebs_phase_e                    phase;       // Current phase
      logic [5:0]                    cnt;         // Remaining periods in phase
      ebs_chip_select_timing_ctrl_s  tc;          // Latched timing of this cycle
      ebs_req_s                      rq;          // Latched request
      logic                          rdySync1;    // Async ready first stage
      logic                          rdySync2;    // Async ready second stage
      logic                          reqReady;    // Idle and accepting
      logic                          rdataValid;  // Read data strobe
      logic [DATA_W-1:0]             rdata;       // Captured read data
      ebs_bus_s                      bus;         // Pin outputs
      logic                          refEn;       // High-speed driver enable
   } ebs_state_s;

   ebs_state_s stateFf;       // Registered state
   ebs_state_s nxtState;      // Next state

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Chip select one-hot, active low
   function automatic logic [3:0] csDecode(input logic [1:0] idx);
      csDecode = ~(4'h1 << idx);
   endfunction : csDecode

   // Setup length: base 1 or 2 plus window extension
   function automatic logic [5:0] setupLen(input ebs_chip_select_timing_ctrl_s t,
                                           input logic w);
      setupLen = {5'h00, t.addressSetupLen} + {4'h0, SETUP_BASE_MIN}
                 + (w ? {4'h0, t.windowExtraLen} : 6'h00);
   endfunction : setupLen

   // Ready level after polarity, taken from sync path when async
   logic readyRaw;            // Polarity-corrected direct ready
   logic readySeen;           // Ready as used at the sample point
   always_comb
   begin
      readyRaw  = stateFf.tc.readyActiveHigh ? readyIn : ~readyIn;
      readySeen = stateFf.tc.readyAsync ? stateFf.rdySync2 : readyRaw;
   end

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb
   begin
      nxtState            = stateFf;
      nxtState.rdataValid = 1'b0;
      nxtState.refEn      = 1'b1;
      // Ready synchroniser; stage one feeds stage two only
      nxtState.rdySync1   = readyRaw;
      nxtState.rdySync2   = stateFf.rdySync1;
      case (stateFf.phase)
         PH_IDLE:
         begin
            nxtState.reqReady = 1'b1;
            if (reqValid && stateFf.reqReady)
            begin
               // Latch timing so mid-cycle changes cannot tear a cycle
               nxtState.tc               = chipSelectTimingCtrl[req.chipSel];
               nxtState.rq               = req;
               nxtState.reqReady         = 1'b0;
               nxtState.phase            = PH_SETUP;
               nxtState.cnt              = setupLen(chipSelectTimingCtrl[req.chipSel],
                                                    req.windowChange) - 6'h01;
               nxtState.bus.addr         = req.addr;
               nxtState.bus.chipSelect_n = csDecode(req.chipSel);
               nxtState.bus.dataOe       = 1'b0;
            end
         end
         PH_SETUP:
         begin
            if (stateFf.cnt != 6'h00)
               nxtState.cnt = stateFf.cnt - 6'h01;
            else
            begin
               // Enter next nonzero phase; zero phases are skipped
               if (stateFf.tc.commandDelayLen != 2'h0)
               begin
                  nxtState.phase = PH_CMD;
                  nxtState.cnt   = {4'h0, stateFf.tc.commandDelayLen} - 6'h01;
               end
               else if (stateFf.tc.writeSetupTristateLen)
               begin
                  nxtState.phase = PH_WSETUP;
                  nxtState.cnt   = 6'h00;
               end
               else
               begin
                  nxtState.phase = PH_ACCESS;
                  nxtState.cnt   = {1'b0, stateFf.tc.accessLen};
               end
               // Write data drives from command phase on
               nxtState.bus.dataOut = stateFf.rq.wdata;
               nxtState.bus.dataOe  = stateFf.rq.write;
               if (stateFf.tc.commandDelayLen == 2'h0 && !stateFf.tc.writeSetupTristateLen)
               begin
                  nxtState.bus.readStrobe_n  = stateFf.rq.write;
                  nxtState.bus.writeStrobe_n = ~stateFf.rq.write;
               end
            end
         end
         PH_CMD:
         begin
            if (stateFf.cnt != 6'h00)
               nxtState.cnt = stateFf.cnt - 6'h01;
            else if (stateFf.tc.writeSetupTristateLen)
            begin
               nxtState.phase = PH_WSETUP;
               nxtState.cnt   = 6'h00;
            end
            else
            begin
               nxtState.phase             = PH_ACCESS;
               nxtState.cnt               = {1'b0, stateFf.tc.accessLen};
               nxtState.bus.readStrobe_n  = stateFf.rq.write;
               nxtState.bus.writeStrobe_n = ~stateFf.rq.write;
            end
         end
         PH_WSETUP:
         begin
            // Single period: strobe goes active at access start
            nxtState.phase             = PH_ACCESS;
            nxtState.cnt               = {1'b0, stateFf.tc.accessLen};
            nxtState.bus.readStrobe_n  = stateFf.rq.write;
            nxtState.bus.writeStrobe_n = ~stateFf.rq.write;
         end
         PH_ACCESS:
         begin
            if (stateFf.cnt != 6'h00)
               nxtState.cnt = stateFf.cnt - 6'h01;
            else if (stateFf.tc.readyEnable && !readySeen)
               nxtState.cnt = 6'h00;
            else
            begin
               // Strobe rises; read data taken on this same edge
               nxtState.bus.readStrobe_n  = 1'b1;
               nxtState.bus.writeStrobe_n = 1'b1;
               if (!stateFf.rq.write)
               begin
                  nxtState.rdata      = busDataIn;
                  nxtState.rdataValid = 1'b1;
               end
               if (stateFf.tc.holdLen != 2'h0)
               begin
                  nxtState.phase = PH_HOLD;
                  nxtState.cnt   = {4'h0, stateFf.tc.holdLen} - 6'h01;
               end
               else
               begin
                  nxtState.phase            = PH_IDLE;
                  nxtState.bus.chipSelect_n = 4'hf;
                  nxtState.bus.dataOe       = 1'b0;
                  nxtState.reqReady         = 1'b1;
               end
            end
         end
         PH_HOLD:
         begin
            if (stateFf.cnt != 6'h00)
               nxtState.cnt = stateFf.cnt - 6'h01;
            else
            begin
               nxtState.phase            = PH_IDLE;
               nxtState.bus.chipSelect_n = 4'hf;
               nxtState.bus.dataOe       = 1'b0;
               nxtState.reqReady         = 1'b1;
            end
         end
         default:
         begin
            nxtState.phase = PH_IDLE;
         end
      endcase
      // Async ready adds one wait only where the access count would be zero
      if (nxtState.phase == PH_ACCESS && stateFf.phase != PH_ACCESS
          && stateFf.tc.readyEnable && stateFf.tc.readyAsync
          && nxtState.cnt == 6'h00)
         nxtState.cnt = ASYNC_MIN_WAIT;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         stateFf                   <= '0;
         stateFf.phase             <= PH_IDLE;
         stateFf.bus.readStrobe_n  <= 1'b1;
         stateFf.bus.writeStrobe_n <= 1'b1;
         stateFf.bus.chipSelect_n  <= 4'hf;
      end
      else
         stateFf <= nxtState;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Reference clock is the system clock routed out unchanged
   assign busRefClkOut     = core_clk;
   assign busRefClkHiSpeed = stateFf.refEn;
   assign reqReady         = stateFf.reqReady;
   assign rdataValid       = stateFf.rdataValid;
   assign rdata            = stateFf.rdata;
   assign bus              = stateFf.bus;

endmodule : ebs_sequencer

`default_nettype wire

/* File: bench/ebs_sequencer_monitor.sv */
// Checker of bus cycle phase timing at the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module ebs_sequencer_monitor
#(
   parameter int unsigned NUM_CS = 4    // Number of chip selects
)
(
   // Clock and reset
   input  wire logic                                   core_clk,
   input  wire logic                                   rst_n,
   // Request side
   input  wire ebs_pkg::ebs_chip_select_timing_ctrl_s  chipSelectTimingCtrl [NUM_CS],
   input  wire logic                                   reqValid,
   input  wire ebs_pkg::ebs_req_s                      req,
   input  wire logic                                   reqReady,
   input  wire logic                                   rdataValid,
   // Bus side
   input  wire logic                                   readyIn,
   input  wire ebs_pkg::ebs_bus_s                      bus,
   input  wire logic                                   busRefClkOut,
   input  wire logic                                   busRefClkHiSpeed
);
   import ebs_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // Cycle bookkeeping
   // ----------------------------------------
   ebs_chip_select_timing_ctrl_s cfg_ff;     // Timing latched at take
   logic                         win_ff;     // Window change latched at take
   logic [7:0]                   cnt_ff;     // Cycles since take
   logic [7:0]                   low_ff;     // Cycles with a strobe low
   logic                         strobeLow;  // Either strobe active
   logic                         csIdle;     // No chip select active
   logic                         take;       // Request accepted
   logic                         rdyAct;     // Ready at its active level
   logic [7:0]                   expLead;    // Setup, command and data setup
   logic [7:0]                   minLow;     // Shortest legal access
   assign strobeLow = !bus.readStrobe_n || !bus.writeStrobe_n;
   assign csIdle    = &bus.chipSelect_n;
   assign take      = reqValid && reqReady;
   assign rdyAct    = readyIn == cfg_ff.readyActiveHigh;
   assign expLead   = 8'(cfg_ff.addressSetupLen) + 8'(cfg_ff.commandDelayLen) + 8'h1
                    + 8'(cfg_ff.writeSetupTristateLen) + (win_ff ? 8'(cfg_ff.windowExtraLen) : 8'h0);
   // Async ready costs one wait only where access alone would not
   assign minLow    = 8'(cfg_ff.accessLen) + 8'h1
                    + 8'(cfg_ff.readyAsync && cfg_ff.accessLen == 5'h0);
   // Counters restart at each take so every figure is per cycle
   always_ff @(posedge core_clk)
   begin
      if (!rst_n || take)
      begin
         cnt_ff <= 8'h0;
         low_ff <= 8'h0;
      end
      else
      begin
         cnt_ff <= cnt_ff + 8'h1;
         low_ff <= low_ff + 8'(strobeLow);
      end
      if (take)
      begin
         cfg_ff <= chipSelectTimingCtrl[req.chipSel];
         win_ff <= req.windowChange;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_take; take |=> !reqReady && !csIdle && !strobeLow; endproperty
   a_take: assert property (p_take) else $error("cycle did not open on take");
   property p_sel; take |=> bus.chipSelect_n == ~(4'h1 << $past(req.chipSel)) && bus.addr == $past(req.addr); endproperty
   a_sel: assert property (p_sel) else $error("wrong chip select or address");
   property p_lead; $rose(strobeLow) |-> cnt_ff == expLead; endproperty
   a_lead: assert property (p_lead) else $error("lead length wrong");
   property p_acc; $fell(strobeLow) && !cfg_ff.readyEnable |-> low_ff == 8'(cfg_ff.accessLen) + 8'h1; endproperty
   a_acc: assert property (p_acc) else $error("access length wrong");
   property p_rdyMin; $fell(strobeLow) && cfg_ff.readyEnable |-> low_ff >= minLow; endproperty
   a_rdyMin: assert property (p_rdyMin) else $error("ready access too short");
   property p_rdyEnd; strobeLow && cfg_ff.readyEnable && rdyAct && low_ff >= minLow |-> ##[1:3] !strobeLow; endproperty
   a_rdyEnd: assert property (p_rdyEnd) else $error("ready did not end access");
   property p_hold; $rose(csIdle) |-> reqReady && cnt_ff == expLead + low_ff + 8'(cfg_ff.holdLen); endproperty
   a_hold: assert property (p_hold) else $error("hold length wrong");
   property p_rdv; rdataValid == $rose(bus.readStrobe_n); endproperty
   a_rdv: assert property (p_rdv) else $error("read data not taken at strobe rise");
   property p_clk; $past(rst_n) |-> busRefClkHiSpeed && !busRefClkOut; endproperty
   a_clk: assert property (p_clk) else $error("reference clock output wrong");
endmodule : ebs_sequencer_monitor
`default_nettype wire

/* File: bench/ebs_ext_mem.sv */
// Behavioural external memory with a ready handshake
`timescale 1ns/1ps
`default_nettype none
module ebs_ext_mem
(
   // Clock and bus pins
   input  wire logic                        core_clk,
   input  wire ebs_pkg::ebs_bus_s           bus,
   // Board settings
   input  wire logic [1:0]                  waitCycles,
   input  wire logic                        rdyHigh,
   // Answers
   output var  logic                        readyIn,
   output var  logic [ebs_pkg::DATA_W-1:0]  busDataIn
);
   import ebs_pkg::*;
   logic [DATA_W-1:0] mem [16];     // Small word store
   logic [DATA_W-1:0] last = '0;   // Last word driven
   logic [5:0]        waitCnt = '0; // Strobe-low cycles seen
   logic              strobeLow;    // Either strobe active
   assign strobeLow = !bus.readStrobe_n || !bus.writeStrobe_n;
   // Ready only inside a strobe, so it is gone before the next cycle
   assign readyIn = (strobeLow && waitCnt >= 6'(waitCycles)) == rdyHigh;
   // Released lines show the inverse of the last word, not a stale copy
   assign busDataIn = !bus.readStrobe_n ? mem[bus.addr[3:0]] : ~last;
   always @(posedge core_clk)
   begin
      waitCnt <= strobeLow ? waitCnt + 6'h1 : 6'h0;
      if (!bus.readStrobe_n)
         last <= mem[bus.addr[3:0]];
      if (!bus.writeStrobe_n && bus.dataOe)
         mem[bus.addr[3:0]] <= bus.dataOut;
   end
endmodule : ebs_ext_mem
`default_nettype wire

/* File: bench/ebs_sequencer_tb.sv */
// Testbench for the external bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module ebs_sequencer_tb;
   import ebs_pkg::*;
   logic                         core_clk = 1'b0;  // System clock
   logic                         rst_n = 1'b0;     // Sync reset
   ebs_chip_select_timing_ctrl_s cfg [4] = '{default: '0};
   logic                         reqValid = 1'b0;
   ebs_req_s                     req = '0;
   logic                         reqReady, rdataValid, readyIn, busRefClkOut, busRefClkHiSpeed;
   logic [DATA_W-1:0]            rdata, busDataIn;
   ebs_bus_s                     bus;
   logic [1:0]                   memWait = 2'h0;   // Partner wait cycles
   logic                         rdyHigh = 1'b1;   // Partner ready polarity
   int                           failures = 0;
   int                           samples_checked = 0;
   always #5 core_clk = ~core_clk;
   ebs_sequencer #(.NUM_CS(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .chipSelectTimingCtrl(cfg), .reqValid(reqValid), .req(req), .reqReady(reqReady),
      .rdataValid(rdataValid), .rdata(rdata), .readyIn(readyIn), .busDataIn(busDataIn),
      .bus(bus), .busRefClkOut(busRefClkOut), .busRefClkHiSpeed(busRefClkHiSpeed));
   ebs_ext_mem mem_u (.core_clk(core_clk), .bus(bus), .waitCycles(memWait),
      .rdyHigh(rdyHigh), .readyIn(readyIn), .busDataIn(busDataIn));
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // One whole cycle: edges from take until ready again, strobe-low count
   task automatic run(input logic wr, input logic [3:0] a, input logic [15:0] d,
                      input logic [1:0] cs, input logic win,
                      output int n, output int low, output logic [15:0] rd);
      n = 0;
      low = 0;
      rd = 'x;
      @(posedge core_clk);
      reqValid <= 1'b1;
      req <= '{write: wr, addr: {20'h0, a}, wdata: d, chipSel: cs, windowChange: win};
      @(posedge core_clk);
      reqValid <= 1'b0;
      while (n < 300)
      begin
         @(posedge core_clk);
         #1;
         n++;
         low += int'(!bus.readStrobe_n || !bus.writeStrobe_n);
         if (rdataValid === 1'b1)
            rd = rdata;
         if (reqReady === 1'b1)
            break;
      end
   endtask : run
   task automatic t_reset();
      // Release on the sixteenth edge; outputs still show reset one step later
      rst_n <= 1'b1;
      // Extremes and mixed lengths per chip select
      cfg[0] <= '{1'b0, 2'h0, 2'h0, 1'b0, 5'h00, 2'h0, 1'b0, 1'b1, 1'b0};
      cfg[1] <= '{1'b1, 2'h3, 2'h3, 1'b1, 5'h1f, 2'h3, 1'b0, 1'b1, 1'b0};
      cfg[2] <= '{1'b0, 2'h2, 2'h1, 1'b0, 5'h04, 2'h1, 1'b0, 1'b1, 1'b0};
      cfg[3] <= '{1'b1, 2'h1, 2'h2, 1'b1, 5'h02, 2'h2, 1'b0, 1'b1, 1'b0};
      #1;
      check("reset outputs", 16'h0fc0, {reqReady, rdataValid, busRefClkHiSpeed, bus.dataOe,
            bus.readStrobe_n, bus.writeStrobe_n, bus.chipSelect_n, 6'h00});
      // High just after the rising edge; the monitor sees it low at the edge
      check("reference clock", 16'h1, 16'(busRefClkOut));
      $display("reset test done");
   endtask : t_reset
   // Every chip select, with and without window change, write then read back
   task automatic t_phases();
      int n;
      int low;
      int lead;
      logic [15:0] rd;
      ebs_chip_select_timing_ctrl_s c;
      for (int i = 0; i < 8; i++)
      begin
         c = cfg[i / 2];
         lead = 1 + c.addressSetupLen + (i[0] ? c.windowExtraLen : 2'h0) + c.commandDelayLen
              + c.writeSetupTristateLen;
         for (int w = 1; w >= 0; w--)
         begin
            run(w[0], 4'(i), {12'h5a3, 1'b0, 3'(i)}, 2'(i / 2), i[0], n, low, rd);
            check("cycle length", 16'(lead + c.accessLen + 1 + c.holdLen), 16'(n));
            check("strobe length", 16'(c.accessLen + 1), 16'(low));
         end
         check("read data", {12'h5a3, 1'b0, 3'(i)}, rd);
      end
      $display("phase test done");
   endtask : t_phases
   // Waits, both polarities, synchronous and asynchronous ready
   task automatic t_ready();
      int n;
      int low;
      int mn;
      logic [15:0] rd;
      for (int k = 0; k < 16; k++)
      begin
         @(posedge core_clk);
         memWait <= 2'(k);
         rdyHigh <= k[2];
         cfg[0] <= '{1'b0, 2'h0, 2'h0, 1'b0, 5'h00, 2'h0, 1'b1, k[2], k[3]};
         mn = (k[3] && k % 4 == 0) ? 2 : k % 4 + 1;
         run(1'b0, 4'h0, 16'h0, 2'h0, 1'b0, n, low, rd);
         check("ready waits", 16'h1, 16'(low >= mn && low <= mn + 3));
         check("ready data", 16'h5a30, rd);
      end
      $display("ready test done");
   endtask : t_ready
   initial
   begin
      repeat (16) @(posedge core_clk);
      t_reset();
      t_phases();
      t_ready();
      end_of_test();
   end
   // Hang guard, far beyond the few hundred cycles the tests need
   initial
   begin
      #100000;
      failures++;
      end_of_test();
   end
endmodule : ebs_sequencer_tb
bind ebs_sequencer ebs_sequencer_monitor #(.NUM_CS(NUM_CS)) mon_u (.core_clk(core_clk),
   .rst_n(rst_n), .chipSelectTimingCtrl(chipSelectTimingCtrl), .reqValid(reqValid),
   .req(req), .reqReady(reqReady), .rdataValid(rdataValid), .readyIn(readyIn), .bus(bus),
   .busRefClkOut(busRefClkOut), .busRefClkHiSpeed(busRefClkHiSpeed));
`default_nettype wire
